// ==== common/duart_pkg.sv ====
// duart_pkg: shared constants and carrier types for the two-channel uart pin block
// assumes one 100 MHz core clock and a synchronous active-high reset
package duart_pkg;

    // register addresses selected by the three address inputs
    localparam logic [2:0] ADDR_DATA = 3'h0;       // rx fifo read / tx fifo write
    localparam logic [2:0] ADDR_TRIG = 3'h1;       // trigger levels: [7:4] tx spaces, [3:0] rx fill
    localparam logic [2:0] ADDR_FEAT = 3'h2;       // enhanced_feature_reg
    localparam logic [2:0] ADDR_MCTL = 3'h4;       // modem_control_reg
    localparam logic [2:0] ADDR_LSTAT = 3'h5;      // line status
    localparam logic [2:0] ADDR_MSTAT = 3'h6;      // modem_status_reg
    localparam logic [2:0] ADDR_DIV = 3'h7;        // baud divisor

    // field positions
    localparam int MCTL_RTS_BIT = 1;
    localparam int MCTL_LOOP_BIT = 4;
    localparam int FEAT_ACTS_BIT = 7;
    localparam int MSTAT_CTS_BIT = 4;

    // reset values
    localparam logic [7:0] TRIG_RESET = 8'h11;
    localparam logic [7:0] DIV_RESET = 8'h01;

    // fifo and timing
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam int OVS = 16;                       // samples per bit
    localparam int TIMEOUT_BITS = 40;              // four characters of idle line
    localparam int TIMEOUT_W = 10;

    // host bus request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } duart_req_type;

    // received word with framing error flag
    typedef struct packed {
        logic       ferr;
        logic [7:0] data;
    } duart_word_type;

endpackage

// ==== core/duart_skid.sv ====
// duart_skid: two-entry buffer with valid/ready both sides
// assumes synchronous inputs on core_clk
`timescale 1ns/100ps
module duart_skid (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire duart_pkg::duart_word_type in_word,
    output logic out_valid,
    input wire logic out_ready,
    output duart_pkg::duart_word_type out_word
);
    import duart_pkg::*;

    duart_word_type mem_q [2];                     // entry storage
    logic rd_q;                                    // read index
    logic wr_q;                                    // write index
    logic [1:0] cnt_q;                             // occupancy
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_word = mem_q[rd_q];

    ////////////////////////////////////////////////////////////////
    // pointer and count update
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_word;
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    a_skid_no_loss: assert property (@(posedge core_clk) disable iff (rst)
        !in_ready |-> !in_valid) else $error("word offered while buffer full");
endmodule

// ==== core/duart_chan.sv ====
// duart_chan: one uart channel: host registers, fifos, dma ready pins, loopback, cts
// assumes host strobes are synchronous to core_clk, one access per strobe
// Overview of operation
// - rx ready low at trigger or timeout
// - rx ready high on empty or error
// - tx ready low when free space reaches trigger
// - tx ready high when tx fifo full
// - loopback: tx line idle, fed to receiver
// - only selected channel takes bus transfers
// - three address bits pick the register
// - cts input shown in modem status bit4
// - cts gates transmit only with auto-cts enabled
// - read strobe puts addressed register on bus
// - write strobe stores bus into addressed register
// - control bit1 drives rts low; reset high
// - bit zero is first serial bit
`timescale 1ns/100ps
module duart_chan (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic chan_select_n,
    input wire duart_pkg::duart_req_type req,
    output logic [7:0] rdata,
    output logic rdata_en_n,
    output logic serial_out,
    input wire logic serial_in,
    input wire logic clear_to_send_n,
    output logic request_to_send_n,
    output logic rx_dma_ready_n,
    output logic tx_dma_ready_n
);
    import duart_pkg::*;

    function automatic logic [CNT_W-1:0] trig_count(input logic [3:0] t);
        trig_count = (t == 4'h0) ? CNT_W'(1) : {1'b0, t};
    endfunction

    ////////////////////////////////////////////////////////////////
    // host access decode
    wire sel = !chan_select_n;
    wire wr_en = sel && req.wr;
    wire rd_en = sel && req.rd;
    wire [2:0] addr = req.addr;
    logic rd_d1_q;                                                // read edge detect
    logic wr_d1_q;                                                // write edge detect
    wire rd_pulse = rd_en && !rd_d1_q;
    wire wr_pulse = wr_en && !wr_d1_q;

    logic [7:0] trig_q;                                           // trigger levels
    logic [7:0] feat_q;                                           // enhanced feature
    logic [7:0] mctl_q;                                           // modem control
    logic [7:0] div_q;                                            // baud divisor
    wire loop_en = mctl_q[MCTL_LOOP_BIT];
    wire auto_cts = feat_q[FEAT_ACTS_BIT];

    // register writes; data register handled by tx fifo
    always_ff @(posedge core_clk) begin
        if (rst) begin
            trig_q <= TRIG_RESET;
            feat_q <= 8'h00;
            mctl_q <= 8'h00;
            div_q <= DIV_RESET;
            rd_d1_q <= 1'b0;
            wr_d1_q <= 1'b0;
        end else begin
            rd_d1_q <= rd_en;
            wr_d1_q <= wr_en;
            if (wr_pulse) begin
                case (addr)
                    ADDR_TRIG: trig_q <= req.wdata;
                    ADDR_FEAT: feat_q <= req.wdata;
                    ADDR_MCTL: mctl_q <= req.wdata;
                    ADDR_DIV: div_q <= req.wdata;
                    default: ;
                endcase
            end
        end
    end

    assign request_to_send_n = !mctl_q[MCTL_RTS_BIT];

    ////////////////////////////////////////////////////////////////
    // baud tick: one pulse per oversample period from core_clk
    logic [7:0] baud_cnt_q;
    wire baud_tick = (baud_cnt_q == 8'h00);
    always_ff @(posedge core_clk) begin
        if (rst || baud_tick) begin
            baud_cnt_q <= (rst ? DIV_RESET : div_q) - 8'h01;
        end else begin
            baud_cnt_q <= baud_cnt_q - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    // tx fifo
    logic [7:0] txm_q [FIFO_DEPTH];
    logic [PTR_W-1:0] txw_q;
    logic [PTR_W-1:0] txr_q;
    logic [CNT_W-1:0] txc_q;
    wire tx_full = (txc_q == CNT_W'(FIFO_DEPTH));
    wire tx_push = wr_pulse && (addr == ADDR_DATA) && !tx_full;
    wire [CNT_W-1:0] tx_free = CNT_W'(FIFO_DEPTH) - txc_q;
    logic tx_pop;

    // tx ready low with enough spaces, high when full
    assign tx_dma_ready_n = tx_full || (tx_free < trig_count(trig_q[7:4]));

    // tx shifter: start, 8 data lsb first, stop
    logic [9:0] tsh_q;
    logic [3:0] tbit_q;
    logic [3:0] tos_q;
    logic tbusy_q;
    wire cts_ok = !auto_cts || !clear_to_send_n;
    assign tx_pop = !tbusy_q && (txc_q != 0) && cts_ok;
    wire tx_line = tbusy_q ? tsh_q[0] : 1'b1;
    assign serial_out = loop_en ? 1'b1 : tx_line;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            txw_q <= '0;
            txr_q <= '0;
            txc_q <= '0;
            tbusy_q <= 1'b0;
            tsh_q <= 10'h3ff;
            tbit_q <= 4'h0;
            tos_q <= 4'h0;
        end else begin
            if (tx_push) begin
                txm_q[txw_q] <= req.wdata;
                txw_q <= txw_q + PTR_W'(1);
            end
            if (tx_pop) begin
                tsh_q <= {1'b1, txm_q[txr_q], 1'b0};
                txr_q <= txr_q + PTR_W'(1);
                tbusy_q <= 1'b1;
                tbit_q <= 4'h0;
                tos_q <= 4'h0;
            end else if (tbusy_q && baud_tick) begin
                tos_q <= tos_q + 4'h1;
                if (tos_q == 4'(OVS - 1)) begin
                    tsh_q <= {1'b1, tsh_q[9:1]};
                    tbit_q <= tbit_q + 4'h1;
                    if (tbit_q == 4'h9) tbusy_q <= 1'b0;
                end
            end
            txc_q <= txc_q + CNT_W'(tx_push) - CNT_W'(tx_pop);
        end
    end

    ////////////////////////////////////////////////////////////////
    // receiver: loopback replaces the pin input
    wire rx_in = loop_en ? tx_line : serial_in;
    logic rbusy_q;
    logic [3:0] ros_q;
    logic [3:0] rbit_q;
    logic [8:0] rsh_q;
    logic rx_done;
    duart_word_type rx_word;
    assign rx_word = '{ferr: !rx_in, data: rsh_q[8:1]};
    assign rx_done = rbusy_q && baud_tick && (ros_q == 4'(OVS/2 - 1)) && (rbit_q == 4'h9);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rbusy_q <= 1'b0;
            ros_q <= 4'h0;
            rbit_q <= 4'h0;
            rsh_q <= '0;
        end else if (baud_tick) begin
            if (!rbusy_q) begin
                if (!rx_in) begin
                    rbusy_q <= 1'b1;
                    ros_q <= 4'h0;
                    rbit_q <= 4'h0;
                end
            end else begin
                ros_q <= ros_q + 4'h1;
                if (ros_q == 4'(OVS/2 - 1)) begin
                    rsh_q <= {rx_in, rsh_q[8:1]};
                    rbit_q <= rbit_q + 4'h1;
                    if (rbit_q == 4'h9 || (rbit_q == 4'h0 && rx_in)) rbusy_q <= 1'b0; // stop, or false start
                end
            end
        end
    end

    // skid buffer decouples receiver from a full rx fifo
    logic sk_valid;
    logic sk_ready;
    duart_word_type sk_word;
    duart_skid u_skid (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(rx_done),
        .in_ready(),
        .in_word(rx_word),
        .out_valid(sk_valid),
        .out_ready(sk_ready),
        .out_word(sk_word)
    );

    ////////////////////////////////////////////////////////////////
    // rx fifo with per-word error flags
    duart_word_type rxm_q [FIFO_DEPTH];
    logic [PTR_W-1:0] rxw_q;
    logic [PTR_W-1:0] rxr_q;
    logic [CNT_W-1:0] rxc_q;
    logic [FIFO_DEPTH-1:0] err_q;                                 // error per slot
    wire rx_full = (rxc_q == CNT_W'(FIFO_DEPTH));
    wire rx_empty = (rxc_q == 0);
    assign sk_ready = !rx_full;
    wire rx_push = sk_valid && sk_ready;
    wire rx_pop = rd_pulse && (addr == ADDR_DATA) && !rx_empty;
    wire rx_err = |err_q;

    // idle timeout in oversample ticks since last rx activity
    logic [TIMEOUT_W-1:0] to_cnt_q;
    wire timeout = !rx_empty && (to_cnt_q >= TIMEOUT_W'(TIMEOUT_BITS * OVS));
    always_ff @(posedge core_clk) begin
        if (rst || rx_push || rx_pop || rbusy_q) begin
            to_cnt_q <= '0;
        end else if (baud_tick && !timeout) begin
            to_cnt_q <= to_cnt_q + TIMEOUT_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxw_q <= '0;
            rxr_q <= '0;
            rxc_q <= '0;
            err_q <= '0;
        end else begin
            if (rx_pop) begin
                err_q[rxr_q] <= 1'b0;
                rxr_q <= rxr_q + PTR_W'(1);
            end
            if (rx_push) begin
                rxm_q[rxw_q] <= sk_word;
                err_q[rxw_q] <= sk_word.ferr;
                rxw_q <= rxw_q + PTR_W'(1);
            end
            rxc_q <= rxc_q + CNT_W'(rx_push) - CNT_W'(rx_pop);
        end
    end

    // rx ready: low at trigger or timeout, high on empty or error
    wire rx_trig = (rxc_q >= trig_count(trig_q[3:0]));
    assign rx_dma_ready_n = rx_empty || rx_err || !(rx_trig || timeout);

    ////////////////////////////////////////////////////////////////
    // read mux; data output registered
    wire [7:0] lstat = {rx_err, !tbusy_q && (txc_q == 0), rx_full, 4'h0, !rx_empty};
    wire [7:0] mstat = {3'h0, !clear_to_send_n, 4'h0};
    logic [7:0] rmux;
    always_comb begin
        case (addr)
            ADDR_DATA: rmux = rxm_q[rxr_q].data;
            ADDR_TRIG: rmux = trig_q;
            ADDR_FEAT: rmux = feat_q;
            ADDR_MCTL: rmux = mctl_q;
            ADDR_LSTAT: rmux = lstat;
            ADDR_MSTAT: rmux = mstat;
            ADDR_DIV: rmux = div_q;
            default: rmux = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd_pulse) begin
            rdata <= rmux;
        end
    end
    assign rdata_en_n = !rd_en;

    ////////////////////////////////////////////////////////////////
    // checks
    a_txrdy_full_high: assert property (@(posedge core_clk) disable iff (rst)
        tx_full |-> tx_dma_ready_n) else $error("tx ready low while full");
    a_txrdy_space_low: assert property (@(posedge core_clk) disable iff (rst)
        (tx_free >= trig_count(trig_q[7:4])) |-> !tx_dma_ready_n) else $error("tx ready stuck");
    a_rxrdy_empty_high: assert property (@(posedge core_clk) disable iff (rst)
        (rx_empty || rx_err) |-> rx_dma_ready_n) else $error("rx ready low while empty");
    a_rxrdy_trig_low: assert property (@(posedge core_clk) disable iff (rst)
        (rx_trig && !rx_empty && !rx_err) |-> !rx_dma_ready_n) else $error("rx ready missed");
    a_loop_line_idle: assert property (@(posedge core_clk) disable iff (rst)
        loop_en |-> serial_out) else $error("tx pin active in loopback");
    a_unsel_no_write: assert property (@(posedge core_clk) disable iff (rst)
        chan_select_n |=> $stable(mctl_q)) else $error("unselected write taken");
    a_rts_follow_ctl: assert property (@(posedge core_clk) disable iff (rst)
        (wr_pulse && addr == ADDR_MCTL) |=> request_to_send_n == !$past(req.wdata[MCTL_RTS_BIT]))
        else $error("rts not following control");
    a_cts_gates_tx: assert property (@(posedge core_clk) disable iff (rst)
        (auto_cts && clear_to_send_n) |-> !tx_pop) else $error("tx started without cts");
    a_mstat_cts: assert property (@(posedge core_clk) disable iff (rst)
        (rd_pulse && addr == ADDR_MSTAT) |=> rdata[MSTAT_CTS_BIT] == !$past(clear_to_send_n))
        else $error("cts status wrong");
endmodule

// ==== core/duart_top.sv ====
// duart_top: two independent channels sharing host bus and clock
// assumes all inputs synchronous to core_clk
`timescale 1ns/100ps
module duart_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic chan_select_n_ch0,
    input wire logic chan_select_n_ch1,
    input wire logic reg_addr_bit0,
    input wire logic reg_addr_bit1,
    input wire logic reg_addr_bit2,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic serial_out_ch0,
    output logic serial_out_ch1,
    input wire logic serial_in_ch0,
    input wire logic serial_in_ch1,
    input wire logic clear_to_send_n_ch0,
    input wire logic clear_to_send_n_ch1,
    output logic request_to_send_n_ch0,
    output logic request_to_send_n_ch1,
    output logic rx_dma_ready_n_ch0,
    output logic rx_dma_ready_n_ch1,
    output logic tx_dma_ready_n_ch0,
    output logic tx_dma_ready_n_ch1
);
    import duart_pkg::*;

    duart_req_type req;
    assign req = '{rd: !host_read_strobe_n, wr: !host_write_strobe_n,
                   addr: {reg_addr_bit2, reg_addr_bit1, reg_addr_bit0}, wdata: data_in};
    logic [7:0] rd0;
    logic [7:0] rd1;
    logic en0_n;
    logic en1_n;

    // channel copies; identical logic, own pins
    duart_chan u_ch0 (
        .core_clk(core_clk), .rst(rst), .chan_select_n(chan_select_n_ch0), .req(req),
        .rdata(rd0), .rdata_en_n(en0_n), .serial_out(serial_out_ch0), .serial_in(serial_in_ch0),
        .clear_to_send_n(clear_to_send_n_ch0), .request_to_send_n(request_to_send_n_ch0),
        .rx_dma_ready_n(rx_dma_ready_n_ch0), .tx_dma_ready_n(tx_dma_ready_n_ch0)
    );
    duart_chan u_ch1 (
        .core_clk(core_clk), .rst(rst), .chan_select_n(chan_select_n_ch1), .req(req),
        .rdata(rd1), .rdata_en_n(en1_n), .serial_out(serial_out_ch1), .serial_in(serial_in_ch1),
        .clear_to_send_n(clear_to_send_n_ch1), .request_to_send_n(request_to_send_n_ch1),
        .rx_dma_ready_n(rx_dma_ready_n_ch1), .tx_dma_ready_n(tx_dma_ready_n_ch1)
    );

    // channel 0 wins if both selected during a read
    assign data_out = !en0_n ? rd0 : rd1;
    assign data_oe_n = en0_n && en1_n;
endmodule

// ==== testbench/duart_line_model.sv ====
// duart_line_model: far end of one serial channel, a remote uart with 8n1 framing
// assumes the channel runs at reset divisor, BIT_CYCLES core clocks per bit
`timescale 1ns/100ps
module duart_line_model #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic core_clk,
    input wire logic line_from_dut,
    output logic line_to_dut
);
    logic [7:0] rx_byte; // last byte decoded from the dut line
    int rx_count; // bytes decoded so far

    ////////////////////////////////////////////////////////////////////////
    // idle line stays high between frames
    initial begin
        line_to_dut = 1'b1;
        rx_byte = 8'h00;
        rx_count = 0;
    end

    // one frame, bit zero first; stop_bit low makes a framing error
    task automatic send(input logic [7:0] b, input logic stop_bit);
        @(posedge core_clk);
        line_to_dut <= 1'b0;
        repeat (BIT_CYCLES) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            line_to_dut <= b[i];
            repeat (BIT_CYCLES) @(posedge core_clk);
        end
        line_to_dut <= stop_bit;
        repeat (BIT_CYCLES) @(posedge core_clk);
        line_to_dut <= 1'b1;
        repeat (BIT_CYCLES) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // receiver: mid-bit sampling, bit zero arrives first
    always begin
        @(negedge line_from_dut);
        repeat (BIT_CYCLES / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge core_clk);
            rx_byte[i] = line_from_dut;
        end
        repeat (BIT_CYCLES) @(posedge core_clk);
        rx_count++;
    end
endmodule

// ==== testbench/duart_top_tb.sv ====
// duart_top_tb: host-side sequences against both channels of duart_top
// assumes duart_pkg constants and one line model per channel
`timescale 1ns/100ps
module duart_top_tb;
    import duart_pkg::*;
    logic core_clk, rst;
    logic [1:0] sel_n, cts_n; // per-channel select and clear-to-send
    logic [2:0] ra; // register address pins, bit 2 most significant
    logic rd_n, wr_n;
    logic [7:0] data_in, data_out, rd;
    logic data_oe_n, so0, so1, si0, si1, rts0, rts1, rxr0, rxr1, txr0, txr1;
    logic loop_watch, bad_tx; // watch for the external line moving in loopback
    int fails, samples_checked, n;

    duart_top dut (.core_clk(core_clk), .rst(rst), .chan_select_n_ch0(sel_n[0]), .chan_select_n_ch1(sel_n[1]),
        .reg_addr_bit0(ra[0]), .reg_addr_bit1(ra[1]), .reg_addr_bit2(ra[2]), .host_read_strobe_n(rd_n),
        .host_write_strobe_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .serial_out_ch0(so0), .serial_out_ch1(so1), .serial_in_ch0(si0), .serial_in_ch1(si1),
        .clear_to_send_n_ch0(cts_n[0]), .clear_to_send_n_ch1(cts_n[1]), .request_to_send_n_ch0(rts0),
        .request_to_send_n_ch1(rts1), .rx_dma_ready_n_ch0(rxr0), .rx_dma_ready_n_ch1(rxr1),
        .tx_dma_ready_n_ch0(txr0), .tx_dma_ready_n_ch1(txr1));
    duart_line_model #(.BIT_CYCLES(16)) far0 (.core_clk(core_clk), .line_from_dut(so0), .line_to_dut(si0));
    duart_line_model #(.BIT_CYCLES(16)) far1 (.core_clk(core_clk), .line_from_dut(so1), .line_to_dut(si1));

    ////////////////////////////////////////////////////////////////////////
    // clock and loopback line watcher
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (loop_watch && so0 !== 1'b1) bad_tx <= 1'b1;
    end

    // verdict and end of run
    task automatic stop_test();
        if (fails == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one host access: strobe low for two edges, read data taken while the strobe is still low
    task automatic acc(input int ch, input logic wr, input logic [2:0] addr, input logic [7:0] wd);
        @(posedge core_clk);
        sel_n[ch] <= 1'b0;
        ra <= addr;
        data_in <= wd;
        if (wr) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        @(posedge core_clk);
        #1;
        if (!wr) begin
            chk({7'h00, data_oe_n}, 8'h00, "output enable");
            rd = data_out;
        end
        @(posedge core_clk);
        sel_n <= 2'b11;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        #1;
    endtask

    // pin picker: kind 0 rx ready, 1 tx ready
    function automatic logic pin(input int kind, input int ch);
        if (kind == 0) return ch ? rxr1 : rxr0;
        return ch ? txr1 : txr0;
    endfunction

    // bounded wait for a ready pin to reach a level
    task automatic wait_pin(input int kind, input int ch, input logic val, input int bound);
        n = 0;
        while (pin(kind, ch) !== val) begin
            if (n == bound) begin
                fails++;
                $display("mismatch at %0t: ready pin wait ran out", $time);
                stop_test();
            end
            @(posedge core_clk);
            #1;
            n++;
        end
        chk({7'h00, pin(kind, ch)}, {7'h00, val}, "ready pin");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        sel_n = 2'b11;
        cts_n = 2'b11;
        ra = 3'h0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        data_in = 8'h00;
        loop_watch = 1'b0;
        bad_tx = 1'b0;
        fails = 0;
        samples_checked = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        // levels out of reset on both channels
        chk({rts1, rts0, rxr1, rxr0, txr1, txr0, so1, so0}, 8'hf3, "reset pins");
        // register readback at the trigger and feature addresses, one channel at a time
        acc(1, 1'b1, ADDR_TRIG, 8'h00);
        acc(0, 1'b1, ADDR_TRIG, 8'h00);
        acc(1, 1'b0, ADDR_TRIG, 8'h00);
        chk(rd, 8'h00, "trigger readback");
        acc(0, 1'b1, ADDR_FEAT, 8'h40);
        acc(1, 1'b0, ADDR_FEAT, 8'h00);
        chk(rd, 8'h00, "other channel untouched");
        acc(0, 1'b0, ADDR_FEAT, 8'h00);
        chk(rd, 8'h40, "feature readback");
        acc(0, 1'b1, ADDR_FEAT, 8'h00);
        // clear-to-send is status only without auto flow control
        @(posedge core_clk);
        cts_n[0] <= 1'b0;
        acc(0, 1'b0, ADDR_MSTAT, 8'h00);
        chk({7'h00, rd[MSTAT_CTS_BIT]}, 8'h01, "cts status low");
        acc(1, 1'b0, ADDR_MSTAT, 8'h00);
        chk({7'h00, rd[MSTAT_CTS_BIT]}, 8'h00, "cts status other");
        // loopback with rts on channel 0
        acc(0, 1'b1, ADDR_MCTL, 8'h12);
        #1;
        chk({6'h00, rts1, rts0}, 8'h02, "rts pins");
        loop_watch <= 1'b1;
        acc(0, 1'b1, ADDR_DATA, 8'ha5);
        wait_pin(0, 0, 1'b0, 600);
        chk({7'h00, bad_tx}, 8'h00, "line quiet in loopback");
        acc(0, 1'b0, ADDR_DATA, 8'h00);
        chk(rd, 8'ha5, "looped byte");
        wait_pin(0, 0, 1'b1, 4);
        loop_watch <= 1'b0;
        chk(far0.rx_count[7:0], 8'h00, "nothing sent outside");
        acc(0, 1'b1, ADDR_MCTL, 8'h00);
        #1;
        chk({7'h00, rts0}, 8'h01, "rts released");
        // one byte below a fill trigger of two: ready comes only from the idle timeout
        acc(1, 1'b1, ADDR_TRIG, 8'h02);
        far1.send(8'h35, 1'b1);
        #1;
        chk({7'h00, rxr1}, 8'h01, "rx ready below trigger");
        acc(1, 1'b0, ADDR_LSTAT, 8'h00);
        chk(rd, 8'h41, "line status");
        wait_pin(0, 1, 1'b0, 800);
        acc(1, 1'b0, ADDR_DATA, 8'h00);
        chk(rd, 8'h35, "received byte");
        wait_pin(0, 1, 1'b1, 4);
        // a framing error keeps the rx ready pin high
        far1.send(8'h5a, 1'b0);
        repeat (200) @(posedge core_clk);
        #1;
        chk({7'h00, rxr1}, 8'h01, "rx ready with error");
        acc(1, 1'b0, ADDR_DATA, 8'h00);
        chk(rd, 8'h5a, "errored byte");
        // auto flow control holds the transmitter, fifo fills
        acc(1, 1'b1, ADDR_FEAT, 8'h80);
        n = 0;
        while (txr1 !== 1'b1 && n < 20) begin
            acc(1, 1'b1, ADDR_DATA, 8'h61 + n[7:0]);
            n++;
        end
        chk({7'h00, txr1}, 8'h01, "tx ready at full");
        chk({7'h00, n == FIFO_DEPTH}, 8'h01, "fifo depth");
        repeat (400) @(posedge core_clk);
        chk(far1.rx_count[7:0], 8'h00, "held by cts");
        cts_n[1] <= 1'b0;
        wait_pin(1, 1, 1'b0, 600);
        // take the first byte before the second frame overwrites it in the model
        n = 0;
        while (far1.rx_count == 0 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        #1;
        chk(far1.rx_byte, 8'h61, "first byte out");
        chk({7'h00, far1.rx_count > 0}, 8'h01, "released by cts");
        stop_test();
    end
endmodule
